/* rtl/wwr_pkg.sv */
// package for the window watchdog with supply reset
// assumes a single 125 MHz clock domain
package wwr_pkg;

    // ==========================================
    // timing
    localparam int CLK_MHZ = 125;
    localparam int TICK_US = 10;
    localparam int TICK_CYC = TICK_US * CLK_MHZ;
    // intervals in microseconds, nominal for the reference capacitor
    localparam int TRIG_TIMEOUT_US = 46000;
    localparam int DP_INTERVAL_US = 11500;
    localparam int FAULT_LOW_US = 11500;
    localparam int RELEASE_DLY_US = 11500;
    // interval lengths in ticks
    localparam int TRIG_TIMEOUT_TK = TRIG_TIMEOUT_US / TICK_US;
    localparam int DP_INTERVAL_TK = DP_INTERVAL_US / TICK_US;
    localparam int FAULT_LOW_TK = FAULT_LOW_US / TICK_US;
    localparam int RELEASE_DLY_TK = RELEASE_DLY_US / TICK_US;
    localparam int CNT_W = 16;
    localparam int PRE_W = 12;

    // ==========================================
    // watchdog states
    typedef enum logic [3:0] {
        WWR_IDLE   = 4'h1,
        WWR_OPEN   = 4'h2,
        WWR_CLOSED = 4'h4,
        WWR_FAULT  = 4'h8
    } wwr_state_t;

    // ==========================================
    // supply comparator inputs
    typedef struct packed {
        logic above_release;
        logic below_detect;
    } wwr_supply_t;

    // ==========================================
    // outputs
    typedef struct packed {
        logic uv_reset_n;
        logic wdt_fault_n;
        logic combined_n;
    } wwr_out_t;

endpackage : wwr_pkg

/* rtl/wwr_top.sv */
// window watchdog plus undervoltage reset, one combined active-low output
// assumes the supply comparator flags and trigger are synchronous to clk_i
`timescale 1ns/1ps

module wwr_top
    import wwr_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_CYC,
    parameter int TIMEOUT_TICKS = TRIG_TIMEOUT_TK,
    parameter int DP_TICKS = DP_INTERVAL_TK,
    parameter int FAULT_TICKS = FAULT_LOW_TK,
    parameter int RELEASE_TICKS = RELEASE_DLY_TK
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // monitoring control and trigger
    input wire logic wdt_enable_i,
    input wire logic trigger_input_i,
    // supply comparators
    input wire wwr_pkg::wwr_supply_t supply_i,
    // outputs
    output logic wdt_fault_output_o,
    output logic undervoltage_reset_output_o,
    output logic combined_reset_output_o,
    output wwr_pkg::wwr_out_t status_o
);
    import wwr_pkg::*;

    // ==========================================
    // tick prescaler
    logic [PRE_W-1:0] pre_q;
    logic [PRE_W-1:0] pre_d;
    wire tick = (pre_q == PRE_W'(TICK_CYCLES - 1));
    assign pre_d = tick ? '0 : pre_q + 1'b1;

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            pre_q <= '0;
        end else begin
            pre_q <= pre_d;
        end
    end

    // ==========================================
    // undervoltage detector
    logic uv_q;
    logic uv_d;
    logic [CNT_W-1:0] rd_q;
    logic [CNT_W-1:0] rd_d;
    wire rd_done = (rd_q >= CNT_W'(RELEASE_TICKS));
    // delay counts only above release; any dip restarts it from zero
    assign rd_d = (supply_i.below_detect || !supply_i.above_release) ? '0
                : (tick && !rd_done) ? rd_q + 1'b1 : rd_q;
    assign uv_d = supply_i.below_detect ? 1'b0
                : (supply_i.above_release && rd_done) ? 1'b1 : uv_q;

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            uv_q <= 1'b0;
            rd_q <= '0;
        end else begin
            uv_q <= uv_d;
            rd_q <= rd_d;
        end
    end

    // ==========================================
    // watchdog
    wwr_state_t st_q;
    wwr_state_t st_d;
    logic [CNT_W-1:0] win_q;
    logic [CNT_W-1:0] win_d;
    logic [CNT_W-1:0] to_q;
    logic [CNT_W-1:0] to_d;
    logic trig_q;
    logic wo_q;

    wire active = wdt_enable_i && uv_q;
    wire trig_edge = trigger_input_i && !trig_q;
    wire trig_ok = trig_edge && active && wo_q;
    wire win_end = tick && (win_q == CNT_W'(DP_TICKS - 1));
    wire flt_end = tick && (win_q == CNT_W'(FAULT_TICKS - 1));
    wire to_end = tick && (to_q == CNT_W'(TIMEOUT_TICKS - 1));

    always_comb begin
        st_d = st_q;
        win_d = tick ? win_q + 1'b1 : win_q;
        to_d = tick ? to_q + 1'b1 : to_q;
        case (st_q)
            WWR_IDLE: begin
                win_d = '0;
                to_d = '0;
                if (active) begin
                    st_d = WWR_OPEN;
                end
            end
            WWR_OPEN: begin
                if (!active) begin
                    st_d = WWR_IDLE;
                    win_d = '0;
                    to_d = '0;
                end else if (trig_ok) begin
                    st_d = WWR_CLOSED;
                    win_d = '0;
                    to_d = '0;
                end else if (to_end) begin
                    st_d = WWR_FAULT;
                    win_d = '0;
                end
            end
            WWR_CLOSED: begin
                if (!active) begin
                    st_d = WWR_IDLE;
                    win_d = '0;
                    to_d = '0;
                end else if (trig_ok) begin
                    st_d = WWR_FAULT;
                    win_d = '0;
                end else if (win_end) begin
                    st_d = WWR_OPEN;
                    win_d = '0;
                end
            end
            WWR_FAULT: begin
                // disable does not cut the low time short
                to_d = '0;
                if (flt_end) begin
                    st_d = active ? WWR_OPEN : WWR_IDLE;
                    win_d = '0;
                end
            end
            default: begin
                st_d = WWR_IDLE;
            end
        endcase
        if (!uv_q && st_q != WWR_FAULT) begin
            st_d = WWR_IDLE;
            win_d = '0;
            to_d = '0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            st_q <= WWR_IDLE;
            win_q <= '0;
            to_q <= '0;
            trig_q <= 1'b0;
            wo_q <= 1'b1;
        end else begin
            st_q <= st_d;
            win_q <= win_d;
            to_q <= to_d;
            trig_q <= trigger_input_i;
            wo_q <= (st_d != WWR_FAULT);
        end
    end

    // ==========================================
    // outputs
    assign wdt_fault_output_o = wo_q;
    assign undervoltage_reset_output_o = uv_q;
    assign combined_reset_output_o = uv_q & wo_q;
    assign status_o = '{uv_reset_n: uv_q, wdt_fault_n: wo_q, combined_n: uv_q & wo_q};

    // ==========================================
    // checks
    property p_combined;
        @(posedge clk_i) disable iff (!rst_n_i)
        combined_reset_output_o == (uv_q && wo_q);
    endproperty
    a_combined: assert property (p_combined) else $error("combined output wrong");

    property p_uv_drop;
        @(posedge clk_i) disable iff (!rst_n_i)
        supply_i.below_detect |=> !undervoltage_reset_output_o && rd_q == '0;
    endproperty
    a_uv_drop: assert property (p_uv_drop) else $error("reset not dropped");

    property p_uv_hold;
        @(posedge clk_i) disable iff (!rst_n_i)
        (!uv_q && !supply_i.above_release) |=> !uv_q;
    endproperty
    a_uv_hold: assert property (p_uv_hold) else $error("reset released early");

    property p_uv_rise;
        @(posedge clk_i) disable iff (!rst_n_i)
        $rose(uv_q) |-> $past(rd_q) >= CNT_W'(RELEASE_TICKS);
    endproperty
    a_uv_rise: assert property (p_uv_rise) else $error("release delay short");

    property p_wo_high;
        @(posedge clk_i) disable iff (!rst_n_i)
        (st_q == WWR_OPEN || st_q == WWR_CLOSED) |-> wo_q;
    endproperty
    a_wo_high: assert property (p_wo_high) else $error("fault low outside fault");

    property p_open_trig;
        @(posedge clk_i) disable iff (!rst_n_i)
        (st_q == WWR_OPEN && trig_ok && uv_q) |=> st_q == WWR_CLOSED;
    endproperty
    a_open_trig: assert property (p_open_trig) else $error("trigger not taken");

    property p_double;
        @(posedge clk_i) disable iff (!rst_n_i)
        (st_q == WWR_CLOSED && trig_ok && uv_q) |=> !wo_q;
    endproperty
    a_double: assert property (p_double) else $error("double pulse missed");

    property p_timeout;
        @(posedge clk_i) disable iff (!rst_n_i)
        (st_q == WWR_OPEN && active && !trig_ok && to_end) |=> st_q == WWR_FAULT;
    endproperty
    a_timeout: assert property (p_timeout) else $error("timeout missed");

    property p_fault_hold;
        @(posedge clk_i) disable iff (!rst_n_i)
        (st_q == WWR_FAULT && !flt_end) |=> st_q == WWR_FAULT && !wo_q;
    endproperty
    a_fault_hold: assert property (p_fault_hold) else $error("fault ended early");

    // window transitions and the cycles in which nothing may move
    property p_idle_start;
        @(posedge clk_i) disable iff (!rst_n_i)
        (st_q == WWR_IDLE && active) |=> st_q == WWR_OPEN && to_q == '0;
    endproperty
    a_idle_start: assert property (p_idle_start) else $error("start missed");

    property p_closed_end;
        @(posedge clk_i) disable iff (!rst_n_i)
        (st_q == WWR_CLOSED && active && !trig_ok && win_end) |=> st_q == WWR_OPEN;
    endproperty
    a_closed_end: assert property (p_closed_end) else $error("window not reopened");

    property p_closed_stay;
        @(posedge clk_i) disable iff (!rst_n_i)
        (st_q == WWR_CLOSED && active && !trig_ok && !win_end) |=> st_q == WWR_CLOSED;
    endproperty
    a_closed_stay: assert property (p_closed_stay) else $error("closed left early");

    property p_open_stay;
        @(posedge clk_i) disable iff (!rst_n_i)
        (st_q == WWR_OPEN && active && !trig_ok && !to_end) |=> st_q == WWR_OPEN;
    endproperty
    a_open_stay: assert property (p_open_stay) else $error("open left early");

    property p_deact_clear;
        @(posedge clk_i) disable iff (!rst_n_i)
        ((st_q == WWR_OPEN || st_q == WWR_CLOSED) && !wdt_enable_i) |=>
            st_q == WWR_IDLE && win_q == '0 && to_q == '0;
    endproperty
    a_deact_clear: assert property (p_deact_clear) else $error("counts kept");

    property p_fault_end;
        @(posedge clk_i) disable iff (!rst_n_i)
        (st_q == WWR_FAULT && flt_end && active) |=> st_q == WWR_OPEN && wo_q;
    endproperty
    a_fault_end: assert property (p_fault_end) else $error("fault not ended");

    // trigger edges while disabled must leave no trace in the window state
    property p_trig_ignored;
        @(posedge clk_i) disable iff (!rst_n_i)
        (trig_edge && !wdt_enable_i) |=> st_q != WWR_CLOSED;
    endproperty
    a_trig_ignored: assert property (p_trig_ignored) else $error("trigger taken");

    property p_disabled;
        @(posedge clk_i) disable iff (!rst_n_i)
        (!wdt_enable_i && st_q != WWR_FAULT) |=> st_q == WWR_IDLE && wo_q;
    endproperty
    a_disabled: assert property (p_disabled) else $error("runs while disabled");

    property p_uv_idle;
        @(posedge clk_i) disable iff (!rst_n_i)
        (!uv_q && st_q != WWR_FAULT) |=> st_q == WWR_IDLE;
    endproperty
    a_uv_idle: assert property (p_uv_idle) else $error("runs under reset");

    property p_uv_keep;
        @(posedge clk_i) disable iff (!rst_n_i)
        (uv_q && !supply_i.below_detect) |=> uv_q;
    endproperty
    a_uv_keep: assert property (p_uv_keep) else $error("reset dropped early");

    property p_tick;
        @(posedge clk_i) disable iff (!rst_n_i)
        tick |=> pre_q == '0;
    endproperty
    a_tick: assert property (p_tick) else $error("prescaler not wrapped");

endmodule : wwr_top

/* test/test_window_watchdog_with_reset.sv */
// bench for the watchdog with supply reset, shortened tick counts
// assumes the processor model and design sources are compiled first
`timescale 1ns/1ps
`define CHK(nm, e, a) begin checks_done++; if ((a) !== (e)) begin \
    $display("MISMATCH %s exp %0h got %0h", nm, e, a); error_cnt++; end end

module test_window_watchdog_with_reset;
    import wwr_pkg::*;
    // ==========================================
    // signals
    logic clk_i = 1'b0, rst_n_i = 1'b0, en = 1'b0, go = 1'b0, trig;
    wwr_supply_t sup = 2'b01;
    logic fault_o, uv_o, comb_o;
    wwr_out_t st_o;
    int error_cnt = 0, checks_done = 0, cyc = 0, n;

    always #4 clk_i = ~clk_i;

    wwr_top #(.TICK_CYCLES(4), .TIMEOUT_TICKS(20), .DP_TICKS(5), .FAULT_TICKS(5),
        .RELEASE_TICKS(5)) i_wwr_top (.clk_i(clk_i), .rst_n_i(rst_n_i),
        .wdt_enable_i(en), .trigger_input_i(trig), .supply_i(sup),
        .wdt_fault_output_o(fault_o), .undervoltage_reset_output_o(uv_o),
        .combined_reset_output_o(comb_o), .status_o(st_o));
    wwr_mcu i_wwr_mcu (.clk_i(clk_i), .reset_n_i(comb_o), .go_i(go), .trigger_o(trig));

    // ==========================================
    // helpers
    task automatic report_and_stop();
        if (error_cnt == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : report_and_stop

    // counts falling edges until the chosen output shows v
    task automatic wsig(input int s, input logic v, output int k);
        logic x;
        k = 0;
        do begin
            @(negedge clk_i);
            k++;
            x = (s == 0) ? fault_o : uv_o;
        end while (x !== v && k < 400);
    endtask : wsig

    // trigger falls for a cycle before the next call, so back-to-back calls give two edges
    task automatic pulse();
        go <= 1'b1;
        @(negedge clk_i);
        go <= 1'b0;
        repeat (2) @(negedge clk_i);
    endtask : pulse

    // ==========================================
    // scenarios
    task automatic t_release();
        `CHK("uv_rst", 1'b0, uv_o)
        `CHK("status", 3'h2, st_o)
        rst_n_i <= 1'b1;
        sup <= 2'b00;
        repeat (50) @(negedge clk_i);
        `CHK("uv_hyst", 1'b0, uv_o)
        sup <= 2'b10;
        wsig(1, 1'b1, n);
        `CHK("release", 1'b1, 1'(n >= 14 && n <= 24))
        `CHK("comb_up", 1'b1, comb_o)
    endtask : t_release

    task automatic t_timeout();
        en <= 1'b1;
        wsig(0, 1'b0, n);
        `CHK("timeout", 1'b1, 1'(n >= 74 && n <= 86))
        `CHK("comb_flt", 1'b0, comb_o)
        `CHK("uv_flt", 1'b1, uv_o)
        wsig(0, 1'b1, n);
        `CHK("fault_low", 1'b1, 1'(n >= 14 && n <= 24))
    endtask : t_timeout

    // spacing outlasts the closed window; total outlasts the timeout
    task automatic t_good();
        repeat (5) begin
            pulse();
            repeat (38) @(negedge clk_i);
            `CHK("good_trig", 1'b1, fault_o)
        end
    endtask : t_good

    task automatic t_double();
        pulse();
        repeat (6) @(negedge clk_i);
        pulse();
        wsig(0, 1'b0, n);
        `CHK("dbl_pulse", 1'b1, 1'(n <= 3))
        en <= 1'b0;
        wsig(0, 1'b1, n);
        `CHK("no_shorten", 1'b1, 1'(n >= 12 && n <= 24))
        pulse();
        pulse();
        // fault must stay high for the whole wait, well past one timeout
        wsig(0, 1'b0, n);
        `CHK("disabled", 400, n)
    endtask : t_double

    task automatic t_deact();
        en <= 1'b1;
        repeat (60) @(negedge clk_i);
        en <= 1'b0;
        repeat (10) @(negedge clk_i);
        en <= 1'b1;
        wsig(0, 1'b0, n);
        `CHK("deact_clr", 1'b1, 1'(n >= 74 && n <= 86))
        wsig(0, 1'b1, n);
    endtask : t_deact

    task automatic t_uv();
        repeat (10) @(negedge clk_i);
        sup <= 2'b01;
        wsig(1, 1'b0, n);
        `CHK("uv_fall", 1'b1, 1'(n <= 2))
        sup <= 2'b10;
        wsig(1, 1'b1, n);
        `CHK("uv_rel", 1'b1, 1'(n >= 14 && n <= 24))
        wsig(0, 1'b0, n);
        `CHK("restart", 1'b1, 1'(n >= 74 && n <= 88))
    endtask : t_uv

    // ==========================================
    // sequence and hang guard
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            report_and_stop();
        end
    end

    initial begin
        repeat (16) @(negedge clk_i);
        t_release();
        t_timeout();
        t_good();
        t_double();
        t_deact();
        t_uv();
        report_and_stop();
    end
endmodule : test_window_watchdog_with_reset

/* test/wwr_mcu.sv */
// monitored processor model: sends trigger pulses on request
// assumes requests arrive as one-cycle pulses on go_i
`timescale 1ns/1ps

module wwr_mcu (
    // clock and reset seen by the processor
    input wire logic clk_i,
    input wire logic reset_n_i,
    // request from bench, trigger to watchdog
    input wire logic go_i,
    output logic trigger_o
);
    // ==========================================
    // pulse shaper
    logic [1:0] hold_q;
    initial hold_q = 2'h0;
    // a processor held in reset sends nothing
    always @(negedge clk_i) begin
        if (!reset_n_i) begin
            hold_q <= 2'h0;
        end else if (go_i) begin
            hold_q <= 2'h3;
        end else begin
            hold_q <= {1'b0, hold_q[1]};
        end
    end
    assign trigger_o = hold_q[0];
endmodule : wwr_mcu
